//--- verif/flash_protection_controller_test.sv
// bench for the flash protection controller
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defs.vh"
module flash_protection_controller_test;
  logic clk = 0, nrst = 0, por_n = 1, rd = 0, wr = 0;
  logic [7:0] adr = 0;
  logic [31:0] wd = 0, rdata, fd, v, q;
  logic [1:0] rsp, r;
  logic wt, fv, ff, irq, fw, fq, fi, f, w;
  logic [9:0] fa;
  int errors = 0, checks_done = 0;
  always #2.5 clk = ~clk;
  fpc_flash_protection_controller u_fpc_flash_protection_controller (.clk(clk), .nrst(nrst),
    .por_n(por_n), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wt), .avs_response(rsp),
    .fetch_req(fq), .fetch_is_data(fi), .fetch_addr(fa), .fetch_wait(fw), .fetch_valid(fv),
    .fetch_data(fd), .fetch_fault(ff), .flash_irq(irq));
  fpc_core_model u_fpc_core_model (.clk(clk), .fetch_req(fq), .fetch_is_data(fi),
    .fetch_addr(fa), .fetch_wait(fw), .fetch_valid(fv), .fetch_data(fd), .fetch_fault(ff));
  task final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  // one bus cycle, held until waitrequest low
  task bus(input logic w_, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w_;
    wr <= w_;
    adr <= a;
    wd <= d;
    // waitrequest looked at mid-cycle, request held to the next edge
    do
    begin
      @(negedge clk);
      n++;
    end
    while (wt !== 1'b0 && n < 100);
    if (wt !== 1'b0)
    begin
      errors++;
      final_report;
    end
    @(posedge clk);
    v = rdata;
    r = rsp;
    rd <= 0;
    wr <= 0;
  endtask
  // poll command register until idle
  task poll;
    int k;
    k = 0;
    do
    begin
      bus(0, `FPC_OFS_CMD, 0);
      k++;
    end
    while (v !== 0 && k < 2000);
    if (v !== 0)
    begin
      errors++;
      final_report;
    end
  endtask
  task fe(input logic d, input logic [9:0] a, input logic [31:0] e, input logic ef);
    u_fpc_core_model.fetch(d, a, q, f, w);
    chk(q, e);
    chk(f, ef);
  endtask
  task t_reset;
    bus(0, `FPC_OFS_USEC, 0); chk(v, 32'h31);
    bus(0, `FPC_OFS_RDEN, 0); chk(v, 32'hffffffff);
    bus(0, `FPC_OFS_PGEN, 0); chk(v, 32'hffffffff);
    bus(0, 8'h30, 0); chk(r, 2'b10);
  endtask
  task t_prog;
    bus(1, `FPC_OFS_USEC, 1);
    bus(1, `FPC_OFS_ADDR, 0);
    bus(1, `FPC_OFS_CMD, 32'ha4420002); poll;
    bus(0, `FPC_OFS_RDATA, 0); chk(v, 32'hffffffff);
    bus(1, `FPC_OFS_DATA, 32'h12345678);
    bus(1, `FPC_OFS_CMD, 32'ha4420001); poll;
    bus(1, `FPC_OFS_DATA, 32'hff00ffff);
    bus(1, `FPC_OFS_CMD, 32'ha4420001); poll;
    bus(0, `FPC_OFS_RDATA, 0); chk(v, 32'h12005678);
    bus(0, `FPC_OFS_RAW, 0); chk(v, 2);
  endtask
  task t_irq;
    bus(1, `FPC_OFS_MASK, 2);
    bus(0, `FPC_OFS_CLR, 0); chk(v, 2);
    chk(irq, 1);
    bus(1, `FPC_OFS_CLR, 0);
    bus(0, `FPC_OFS_RAW, 0); chk(v, 2);
    bus(1, `FPC_OFS_CLR, 2);
    bus(0, `FPC_OFS_RAW, 0); chk(v, 0);
    chk(irq, 0);
  endtask
  task t_prot;
    bus(1, `FPC_OFS_PGEN, 32'hfffffffe);
    bus(1, `FPC_OFS_MASK, 1);
    bus(1, `FPC_OFS_DATA, 0);
    bus(1, `FPC_OFS_CMD, 32'ha4420001);
    bus(0, `FPC_OFS_RAW, 0); chk(v, 1);
    chk(irq, 1);
    bus(1, `FPC_OFS_CMD, 32'ha4420002);
    bus(0, `FPC_OFS_CMD, 0); chk(v, 0);
    bus(0, `FPC_OFS_RDATA, 0); chk(v, 32'h12005678);
    bus(1, `FPC_OFS_CLR, 1);
  endtask
  task t_fetch;
    fe(1, 10'h000, 32'h12005678, 0);
    bus(1, `FPC_OFS_RDEN, 32'hfffffffe);
    fe(1, 10'h000, 32'h0, 1);
    fe(0, 10'h000, 32'h12005678, 0);
    fe(1, 10'h020, 32'hffffffff, 0);
  endtask
  task por;
    @(posedge clk);
    por_n <= 0;
    repeat (2) @(posedge clk);
    por_n <= 1;
  endtask
  task t_por;
    por;
    bus(0, `FPC_OFS_PGEN, 0); chk(v, 32'hffffffff);
    bus(1, `FPC_OFS_RDEN, 32'hfffffffd);
    bus(1, `FPC_OFS_ADDR, 0);
    bus(1, `FPC_OFS_CMD, 32'ha4420008);
    por;
    bus(0, `FPC_OFS_RDEN, 0); chk(v, 32'hfffffffd);
  endtask
  task t_whole_array_erase_bit;
    bus(1, `FPC_OFS_CMD, 32'ha4420004);
    u_fpc_core_model.fetch(0, 10'h000, q, f, w);
    chk(w, 1);
    chk(q, 32'hffffffff);
    poll;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1;
    repeat (3) @(posedge clk);
    t_reset;
    t_prog;
    t_irq;
    t_prot;
    t_fetch;
    t_por;
    t_whole_array_erase_bit;
    final_report;
  end
endmodule // flash_protection_controller_test
`default_nettype wire

//--- verif/fpc_chk_asserts.sv
// port checker for the flash protection controller
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defs.vh"
module fpc_chk (
  input wire logic        clk,             // clock
  input wire logic        nrst,            // reset, active low
  input wire logic [7:0]  avs_address,     // byte address
  input wire logic        avs_read,        // read strobe
  input wire logic        avs_write,       // write strobe
  input wire logic [31:0] avs_writedata,   // write data
  input wire logic [31:0] avs_readdata,    // read data
  input wire logic        avs_waitrequest, // stall
  input wire logic [1:0]  avs_response,    // response code
  input wire logic        fetch_req,       // fetch request
  input wire logic        fetch_is_data,   // data read
  input wire logic        fetch_wait,      // held off
  input wire logic        fetch_valid,     // answer pulse
  input wire logic [31:0] fetch_data,      // fetched word
  input wire logic        fetch_fault,     // bus fault
  input wire logic        flash_irq        // interrupt
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);
  // read: stall one cycle, then answer
  sequence s_rd_go; $rose(avs_read); endsequence
  sequence s_rd_end; avs_waitrequest ##1 !avs_waitrequest; endsequence
  property p_rd_lat; s_rd_go |-> s_rd_end; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_go; avs_write |-> !avs_waitrequest; endproperty
  a_wr_go: assert property (p_wr_go) else $error("write stalled");
  property p_unmap;
    avs_read && !avs_waitrequest && avs_address > 8'h24 |-> avs_response == 2'b10;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  property p_fetch; fetch_req && !fetch_wait |=> fetch_valid; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not answered");
  property p_wait; fetch_wait |-> fetch_req; endproperty
  a_wait: assert property (p_wait) else $error("hold-off without request");
  property p_fault;
    fetch_fault |-> fetch_valid && fetch_data == 32'h0 && $past(fetch_is_data);
  endproperty
  a_fault: assert property (p_fault) else $error("bad bus fault");
  property p_instr; fetch_valid && !$past(fetch_is_data) |-> !fetch_fault; endproperty
  a_instr: assert property (p_instr) else $error("instruction fetch faulted");
  property p_irq_hold;
    flash_irq && !(avs_write && (avs_address == `FPC_OFS_CLR ||
      avs_address == `FPC_OFS_MASK)) |=> flash_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped");
  property p_irq_mask;
    avs_write && avs_address == `FPC_OFS_MASK && avs_writedata[1:0] == 2'b00 |=> !flash_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt seen");
endmodule // fpc_chk
bind fpc_flash_protection_controller fpc_chk u_fpc_chk (.clk(clk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .fetch_req(fetch_req),
  .fetch_is_data(fetch_is_data), .fetch_wait(fetch_wait), .fetch_valid(fetch_valid),
  .fetch_data(fetch_data), .fetch_fault(fetch_fault), .flash_irq(flash_irq));
`default_nettype wire

//--- verif/fpc_core_model.sv
// processor-side fetch master model
`timescale 1ns/1ps
`default_nettype none
module fpc_core_model (
  input  wire logic        clk,           // system clock
  output var  logic        fetch_req,     // request level
  output var  logic        fetch_is_data, // high for data reads
  output var  logic [9:0]  fetch_addr,    // word address
  input  wire logic        fetch_wait,    // held off
  input  wire logic        fetch_valid,   // answer pulse
  input  wire logic [31:0] fetch_data,    // word read
  input  wire logic        fetch_fault    // bus fault
);
  initial
  begin
    fetch_req = 0;
    fetch_is_data = 0;
    fetch_addr = 10'h155;
  end
  // hold request until not held off, take answer next cycle
  task fetch(input logic d, input logic [9:0] a, output logic [31:0] q, output logic f, w);
    int n;
    w = 0;
    n = 0;
    @(posedge clk);
    fetch_req <= 1;
    fetch_is_data <= d;
    fetch_addr <= a;
    // look at the hold-off mid-cycle, where it is settled
    do
    begin
      @(negedge clk);
      n++;
      if (fetch_wait) w = 1;
    end
    while (fetch_wait !== 1'b0 && n < 5000);
    @(posedge clk);
    fetch_req <= 0;
    fetch_addr <= ~a; // idle address never repeats
    @(negedge clk);
    q = fetch_valid === 1'b1 ? fetch_data : 32'hx; // no answer reads unknown
    f = fetch_fault;
  endtask
endmodule // fpc_core_model
`default_nettype wire

//--- verilog/fpc_defs.vh
// constants for the flash protection controller
`ifndef FPC_DEFS_VH
`define FPC_DEFS_VH
// register byte offsets
`define FPC_OFS_ADDR      8'h00
`define FPC_OFS_DATA      8'h04
`define FPC_OFS_CMD       8'h08
`define FPC_OFS_RAW       8'h0c
`define FPC_OFS_MASK      8'h10
`define FPC_OFS_CLR       8'h14
`define FPC_OFS_RDEN      8'h18
`define FPC_OFS_PGEN      8'h1c
`define FPC_OFS_USEC      8'h20
`define FPC_OFS_RDATA     8'h24
// command register fields
`define FPC_KEY           16'ha442
`define FPC_CMD_WRITE     0
`define FPC_CMD_ERASE     1
`define FPC_CMD_WHOLE_ARRAY_ERASE_BIT    2
`define FPC_CMD_COMMIT    3
// interrupt flag positions
`define FPC_IRQ_ACCESS    0
`define FPC_IRQ_PROG      1
// reset values
`define FPC_USEC_RST      8'h31
`define FPC_PROT_RST      32'hffffffff
// operation times in microseconds
`define FPC_T_WRITE_US    16'h0014
`define FPC_T_ERASE_US    16'h0019
`endif

//--- verilog/fpc_flash_protection_controller.v
// flash controller with block protection, program and erase timing
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defs.vh"
module fpc_flash_protection_controller #(
  parameter AW        = 10,   // word address bits of array
  parameter BLK_WORDS = 256,  // words per 1-KB erase block
  parameter REGIONS   = 32    // number of 128-byte protection regions
) (
  input  wire        clk,              // 200 MHz system clock
  input  wire        nrst,             // async active-low reset
  input  wire        por_n,            // power-on reset strobe, active low, same clock
  input  wire [7:0]  avs_address,      // register byte address
  input  wire        avs_read,         // register read strobe
  input  wire        avs_write,        // register write strobe
  input  wire [31:0] avs_writedata,    // register write data
  input  wire [3:0]  avs_byteenable,   // byte lanes
  output reg  [31:0] avs_readdata,     // register read data
  output wire        avs_waitrequest,  // stall
  output reg  [1:0]  avs_response,     // 00 ok, 10 slave error
  input  wire        fetch_req,        // array access request
  input  wire        fetch_is_data,    // 1 data read, 0 instruction fetch
  input  wire [AW-1:0] fetch_addr,     // word address
  output wire        fetch_wait,       // access held off
  output reg         fetch_valid,      // answer pulse
  output reg  [31:0] fetch_data,       // read word
  output reg         fetch_fault,      // bus fault pulse
  output wire        flash_irq         // controller interrupt
);
  localparam DEPTH = 1 << AW;          // array words
  localparam BW    = 8;                // log2 of block words
  localparam ST_IDLE = 2'h0;           // waiting for command
  localparam ST_RUN  = 2'h1;           // timing an operation
  localparam ST_APPL = 2'h2;           // applying to array
  localparam ST_DONE = 2'h3;           // completion
  // reset synchroniser
  reg rst_s1;                          // first stage
  reg rst_n;                           // synchronised reset
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end
  reg [31:0]  mem [0:DEPTH-1];         // flash array
  reg [31:0]  addr_reg;                // target address
  reg [31:0]  data_reg;                // write data
  reg [3:0]   cmd_reg;                 // command bits
  reg [1:0]   raw_reg;                 // raw flags
  reg [1:0]   mask_reg;                // interrupt mask
  reg [7:0]   usec_reg;                // cycles per microsecond minus one
  reg [REGIONS-1:0] rden_reg;          // read enables, live
  reg [REGIONS-1:0] pgen_reg;          // program enables, live
  reg [REGIONS-1:0] rden_com;          // committed read clears
  reg [REGIONS-1:0] pgen_com;          // committed program clears
  reg [1:0]   st_reg;                  // operation state
  reg [7:0]   cyc_reg;                 // cycles within a microsecond
  reg [15:0]  us_reg;                  // microseconds left
  reg [AW:0]  wipe_reg;                // erase word pointer
  reg         rd_pend;                 // read answer pending
  reg         set_prog;                // completion event
  reg         set_acc;                 // violation event
  // region index of a word address
  function [4:0] region_of;
    input [AW-1:0] a;
    begin
      region_of = a[AW-1 -: 5];
    end
  endfunction
  wire [AW-1:0] tgt      = addr_reg[AW+1:2];          // target word
  wire          tgt_pgok = pgen_reg[region_of(tgt)];
  wire          busy     = (st_reg != ST_IDLE);
  wire          sel_wr   = avs_write && avs_address == `FPC_OFS_CMD;
  wire          key_ok   = avs_writedata[31:16] == `FPC_KEY;
  wire [1:0]    masked   = raw_reg & mask_reg;
  wire [1:0]    clr_bits = (avs_write && avs_address == `FPC_OFS_CLR) ?
                           avs_writedata[1:0] : 2'h0;
  assign flash_irq       = |masked;
  assign fetch_wait      = busy && fetch_req;
  // reads answer the cycle after the strobe
  assign avs_waitrequest = avs_read && !rd_pend;
  // register reads
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_pend      <= 1'b0;
      avs_readdata <= 32'h0;
      avs_response <= 2'h0;
    end
    else
    begin
      rd_pend      <= avs_read && !rd_pend;
      // response stands with read data until the next read
      if (avs_read && !rd_pend)
      begin
        avs_response <= 2'h0;
        if (avs_address == `FPC_OFS_ADDR)
          avs_readdata <= addr_reg;
        else if (avs_address == `FPC_OFS_DATA)
          avs_readdata <= data_reg;
        else if (avs_address == `FPC_OFS_CMD)
          avs_readdata <= {28'h0, cmd_reg};
        else if (avs_address == `FPC_OFS_RAW)
          avs_readdata <= {30'h0, raw_reg};
        else if (avs_address == `FPC_OFS_MASK)
          avs_readdata <= {30'h0, mask_reg};
        else if (avs_address == `FPC_OFS_CLR)
          avs_readdata <= {30'h0, masked};
        else if (avs_address == `FPC_OFS_RDEN)
          avs_readdata <= rden_reg;
        else if (avs_address == `FPC_OFS_PGEN)
          avs_readdata <= pgen_reg;
        else if (avs_address == `FPC_OFS_USEC)
          avs_readdata <= {24'h0, usec_reg};
        else if (avs_address == `FPC_OFS_RDATA)
          avs_readdata <= mem[tgt];
        else
        begin
          avs_readdata <= 32'h0;                     // unmapped
          avs_response <= 2'h2;
        end
      end
    end
  end
  // plain configuration registers
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_reg <= 32'h0;
      data_reg <= 32'h0;
      mask_reg <= 2'h0;
      usec_reg <= `FPC_USEC_RST;
    end
    else if (avs_write)
    begin
      if (avs_address == `FPC_OFS_ADDR && !busy)
        addr_reg <= avs_writedata;
      else if (avs_address == `FPC_OFS_DATA && !busy)
        data_reg <= avs_writedata;
      else if (avs_address == `FPC_OFS_MASK)
        mask_reg <= avs_writedata[1:0];
      else if (avs_address == `FPC_OFS_USEC && avs_byteenable[0])
        usec_reg <= avs_writedata[7:0];
    end
  end
  // protection bits: clear only, committed clears survive power-on
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rden_reg <= `FPC_PROT_RST;
      pgen_reg <= `FPC_PROT_RST;
      rden_com <= {REGIONS{1'b0}};
      pgen_com <= {REGIONS{1'b0}};
    end
    else if (!por_n)
    begin
      rden_reg <= ~rden_com;
      pgen_reg <= ~pgen_com;
    end
    else if (avs_write && avs_address == `FPC_OFS_RDEN)
      rden_reg <= rden_reg & avs_writedata;
    else if (avs_write && avs_address == `FPC_OFS_PGEN)
      pgen_reg <= pgen_reg & avs_writedata;
    else if (sel_wr && key_ok && !busy && avs_writedata[`FPC_CMD_COMMIT])
    begin
      if (addr_reg[0])
        pgen_com <= pgen_com | ~pgen_reg;
      else
        rden_com <= rden_com | ~rden_reg;
    end
  end
  // operation sequencer
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg   <= ST_IDLE;
      cmd_reg  <= 4'h0;
      cyc_reg  <= 8'h0;
      us_reg   <= 16'h0;
      wipe_reg <= {(AW+1){1'b0}};
      set_prog <= 1'b0;
      set_acc  <= 1'b0;
    end
    else
    begin
      set_prog <= 1'b0;
      set_acc  <= 1'b0;
      case (st_reg)
        ST_IDLE:
        begin
          if (sel_wr && key_ok && |avs_writedata[2:0])
          begin
            // protected targets of write and block erase never reach the timer unless the whole-array erase bit is also set
            if (!avs_writedata[`FPC_CMD_WHOLE_ARRAY_ERASE_BIT] && !tgt_pgok)
              set_acc <= 1'b1;
            else
            begin
              cmd_reg <= {1'b0, avs_writedata[2:0]};
              cyc_reg <= usec_reg;
              us_reg  <= avs_writedata[`FPC_CMD_WRITE] ?
                         `FPC_T_WRITE_US : `FPC_T_ERASE_US;
              st_reg  <= ST_RUN;
            end
          end
        end
        ST_RUN:
        begin
          // count microseconds from the programmed rate
          if (cyc_reg != 8'h0)
            cyc_reg <= cyc_reg - 8'h1;
          else if (us_reg != 16'h1)
          begin
            cyc_reg <= usec_reg;
            us_reg  <= us_reg - 16'h1;
          end
          else
          begin
            wipe_reg <= {(AW+1){1'b0}};
            st_reg   <= ST_APPL;
          end
        end
        ST_APPL:
        begin
          // erase walks one word per cycle
          if (cmd_reg[`FPC_CMD_WRITE])
            st_reg <= ST_DONE;
          else if (cmd_reg[`FPC_CMD_ERASE] && wipe_reg == BLK_WORDS - 1)
            st_reg <= ST_DONE;
          else if (wipe_reg == DEPTH - 1)
            st_reg <= ST_DONE;
          else
            wipe_reg <= wipe_reg + {{AW{1'b0}}, 1'b1};
        end
        default:
        begin
          cmd_reg  <= 4'h0;
          set_prog <= 1'b1;
          st_reg   <= ST_IDLE;
        end
      endcase
    end
  end
  // array update, no reset on storage
  wire [AW-1:0] blk_base = {tgt[AW-1:BW], {BW{1'b0}}};
  always @(posedge clk)
  begin
    if (st_reg == ST_APPL)
    begin
      if (cmd_reg[`FPC_CMD_WRITE])
        mem[tgt] <= mem[tgt] & data_reg;
      else if (cmd_reg[`FPC_CMD_ERASE])
        mem[blk_base | wipe_reg[BW-1:0]] <= 32'hffffffff;
      else if (pgen_reg[region_of(wipe_reg[AW-1:0])])
        mem[wipe_reg[AW-1:0]] <= 32'hffffffff;
    end
  end
  // sticky flags, set wins over clear
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      raw_reg <= 2'h0;
    else
    begin
      raw_reg[`FPC_IRQ_PROG]   <= set_prog |
        (raw_reg[`FPC_IRQ_PROG] & ~clr_bits[`FPC_IRQ_PROG]);
      raw_reg[`FPC_IRQ_ACCESS] <= set_acc |
        (raw_reg[`FPC_IRQ_ACCESS] & ~clr_bits[`FPC_IRQ_ACCESS]);
    end
  end
  // array read port with policy check
  wire rd_ok = rden_reg[region_of(fetch_addr)] || !fetch_is_data;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fetch_valid <= 1'b0;
      fetch_fault <= 1'b0;
      fetch_data  <= 32'h0;
    end
    else
    begin
      fetch_valid <= fetch_req && !busy;
      fetch_fault <= fetch_req && !busy && !rd_ok;
      if (fetch_req && !busy)
        fetch_data <= rd_ok ? mem[fetch_addr] : 32'h0;
    end
  end
endmodule // fpc_flash_protection_controller
`default_nettype wire
